// ---- src/srp_pkg.sv ----
/*
 * Shared constants of the serial register port: frame layout, address map,
 * status byte layout, strobe codes, timing and the controller's own registers.
 * Assumes a single 125 MHz system clock on both ends.
 */
package srp_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_NS = 8;
    localparam int RSSI_WAIT_US = 128;
    localparam int RSSI_WAIT_CYCLES = (RSSI_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_NS = 64;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_SETUP_NS = 25;
    localparam int CS_SETUP_CYCLES = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HOLD_NS = 25;
    localparam int CS_HOLD_CYCLES = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 4;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] HDR_BITS = 5'h08;
    localparam logic [CNT_W-1:0] BUF_BITS = 5'h10;
    localparam logic [CNT_W-1:0] REG_BITS = 5'h18;
    localparam int HDR_RAM_BIT = 7;
    localparam int HDR_READ_BIT = 6;

    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] STROBE_LAST = 6'h0E;
    localparam logic [ADDR_W-1:0] CFG_FIRST = 6'h10;
    localparam logic [ADDR_W-1:0] CFG_LAST = 6'h30;
    localparam int CFG_COUNT = 33;
    localparam logic [ADDR_W-1:0] TXBUF_ADDR = 6'h3E;
    localparam logic [ADDR_W-1:0] RXBUF_ADDR = 6'h3F;
    localparam logic [3:0] NO_OPERATION_STROBE = 4'h0;
    localparam logic [3:0] OSCILLATOR_ENABLE_STROBE = 4'h1;
    localparam logic [3:0] TRANSMIT_FLUSH_STROBE = 4'h9;

    // ----------------------------------------
    // Status byte bit positions
    // ----------------------------------------
    localparam int ST_OSC = 6;
    localparam int ST_UNDERFLOW = 5;
    localparam int ST_CIPHER = 4;
    localparam int ST_TX_ACTIVE = 3;
    localparam int ST_LOCK = 2;
    localparam int ST_RSSI = 1;

    // ----------------------------------------
    // Controller registers and fields
    // ----------------------------------------
    localparam logic [3:0] HR_CMD = 4'h0;
    localparam logic [3:0] HR_WDATA = 4'h4;
    localparam logic [3:0] HR_STATUS = 4'h8;
    localparam logic [3:0] HR_RDATA = 4'hC;
    localparam int CMD_READ_BIT = 6;
    localparam int CMD_STROBE_BIT = 8;
    localparam int STS_BUSY_BIT = 8;
endpackage

// ---- src/srp_if.sv ----
/*
 * Four-wire serial link between the controller and the register port.
 * Assumes the bench joins one controller and one port to it.
 */
interface srp_if;
    logic sclk;
    logic chip_select_low;
    logic mosi;
    logic miso;

    modport device (
        input sclk,
        input chip_select_low,
        input mosi,
        output miso
    );
    modport host (
        output sclk,
        output chip_select_low,
        output mosi,
        input miso
    );
endinterface

// ---- src/srp_sync.sv ----
/*
 * Two-flop synchroniser with edge detection on the synchronised level.
 * Assumes inputs are asynchronous to clock; edges lag the pin by two cycles.
 */
module srp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins and results
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= IDLE;
            sync_q <= IDLE;
            last_q <= IDLE;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign sync_out = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule

// ---- src/srp_device.sv ----
/*
 * Slave end of the serial register port: header decode, 16-bit register file,
 * status byte, command strobes and single-byte buffer access.
 * Assumes the master runs serial mode 0 (clock idles low) slow enough that a
 * half period spans at least four system clocks.
 */
// Decided for this implementation: the strobed register port and the address map.
// Notes on behaviour
// [R01] Four-wire slave; the other party is master
// [R02] 33 registers, 15 strobes, two buffer registers
// [R03] Master clears bit 7 for register access
// [R04] Header bit 6: 0 write, 1 read
// [R05] Master shifts 24 bits, select held low
// [R06] Address then data, both MSB first
// [R07] Read data out in sixteen following clocks
// [R08] Sample data in on rising clock
// [R09] Load register only after bit D0
// [R10] Back-to-back accesses within one select period
// [R11] Registers survive power-down, cleared only by reset
// [R12] Registers writable in any order
// [R13] Status byte out during header bytes
// [R14] Status bits 6,5,4: oscillator, underflow, cipher
// [R15] Status bits 3,2,1: transmit, lock, signal
// [R16] Underflow sticky until transmit flush strobe
// [R17] Signal valid after eight symbol periods receiving
// [R18] No-operation strobe only returns status
// [R19] Strobe address starts its internal sequence
// [R20] Strobe is header only, address 0x00-0x0E
// [R21] Oscillator off: only oscillator enable strobe acts
// [R22] Reject other strobes until oscillator running
// [R23] Strobe runs on header's last falling edge
// [R24] Select high aborts transfer, clears counter
module srp_device #(
    parameter int RSSI_WAIT = srp_pkg::RSSI_WAIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial link
    srp_if.device link,
    // Radio state
    input wire logic oscillator_running,
    input wire logic underflow_event,
    input wire logic cipher_busy,
    input wire logic tx_active,
    input wire logic pll_lock,
    input wire logic rx_enabled,
    // Strobe output
    output logic strobe_valid,
    output logic [3:0] strobe_code,
    // Buffer bytes
    output logic tx_byte_valid,
    output logic [7:0] tx_byte,
    input wire logic [7:0] rx_byte,
    output logic rx_byte_taken,
    // Register read-back
    input wire logic [5:0] cfg_rd_addr,
    output logic [15:0] cfg_rd_data
);
    localparam int RW = $clog2(RSSI_WAIT + 1);

    typedef enum logic [1:0] {
        PH_HDR = 2'b00,
        PH_REG = 2'b01,
        PH_BUF = 2'b10,
        PH_SKIP = 2'b11
    } srp_phase_t;

    function automatic logic cfg_hit(input logic [srp_pkg::ADDR_W-1:0] a);
        return (a >= srp_pkg::CFG_FIRST) && (a <= srp_pkg::CFG_LAST);
    endfunction

    function automatic logic [5:0] cfg_idx(input logic [srp_pkg::ADDR_W-1:0] a);
        return a - srp_pkg::CFG_FIRST;
    endfunction

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [2:0] s_lvl;
    logic [2:0] s_rise;
    logic [2:0] s_fall;

    srp_sync #(.W(3), .IDLE(3'h2)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({link.sclk, link.chip_select_low, link.mosi}),
        .sync_out(s_lvl),
        .rise(s_rise),
        .fall(s_fall)
    );

    wire cs_active = ~s_lvl[1];
    wire cs_start = s_fall[1];
    wire mosi_s = s_lvl[0];
    wire sclk_up = s_rise[2] & cs_active; // R08
    wire sclk_dn = s_fall[2] & cs_active;

    // ----------------------------------------
    // State
    // ----------------------------------------
    srp_phase_t phase_q, phase_d;
    logic [srp_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [15:0] shin_q;
    logic [7:0] hdr_q;
    logic [15:0] shout_q, shout_d;
    logic [15:0] cfg_q [srp_pkg::CFG_COUNT]; // R02
    logic under_q;
    logic [RW-1:0] rssi_q;
    logic strobe_valid_q;
    logic [3:0] strobe_code_q;
    logic tx_valid_q;
    logic [7:0] tx_byte_q;
    logic rx_taken_q;
    logic [15:0] cfg_rd_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [7:0] hdr_in = {shin_q[6:0], mosi_s};
    wire [15:0] word_in = {shin_q[14:0], mosi_s};
    wire [5:0] in_addr = hdr_in[srp_pkg::ADDR_W-1:0];
    wire in_read = hdr_in[srp_pkg::HDR_READ_BIT]; // R04
    wire in_ram = hdr_in[srp_pkg::HDR_RAM_BIT]; // R03
    wire in_strobe = ~in_ram & ~in_read & (in_addr <= srp_pkg::STROBE_LAST); // R20
    wire in_buf = (in_addr == srp_pkg::TXBUF_ADDR) | (in_addr == srp_pkg::RXBUF_ADDR);
    wire hdr_done = sclk_up & (phase_q == PH_HDR) & (cnt_q == srp_pkg::HDR_BITS - 5'h01);
    wire [5:0] h_addr = hdr_q[srp_pkg::ADDR_W-1:0];
    wire h_read = hdr_q[srp_pkg::HDR_READ_BIT];
    wire reg_done = sclk_up & (phase_q == PH_REG) & (cnt_q == srp_pkg::REG_BITS - 5'h01);
    wire buf_done = sclk_up & (phase_q == PH_BUF) & (cnt_q == srp_pkg::BUF_BITS - 5'h01);
    wire cfg_wr = reg_done & ~h_read & cfg_hit(h_addr); // R09 R12
    wire strobe_now = sclk_dn & (phase_q == PH_HDR) & (cnt_q == srp_pkg::HDR_BITS); // R23
    wire [3:0] stb_code = h_addr[3:0];
    // Strobes other than oscillator enable are dropped until it runs
    wire stb_allowed = oscillator_running | (stb_code == srp_pkg::OSCILLATOR_ENABLE_STROBE); // R21 R22
    wire stb_fire = strobe_now & stb_allowed & (stb_code != srp_pkg::NO_OPERATION_STROBE); // R18 R19
    wire flush = stb_fire & (stb_code == srp_pkg::TRANSMIT_FLUSH_STROBE);
    wire signal_strength_valid = (rssi_q == RW'(RSSI_WAIT)); // R17

    wire [7:0] status_byte = {1'b0, oscillator_running, under_q, cipher_busy,
        tx_active, pll_lock, signal_strength_valid, 1'b0}; // R14 R15

    wire [15:0] rd_word = (~h_read && h_addr == srp_pkg::TXBUF_ADDR) ? {status_byte, 8'h00} : // R13
        ~h_read ? 16'h0000 :
        cfg_hit(h_addr) ? cfg_q[cfg_idx(h_addr)] :
        (h_addr == srp_pkg::RXBUF_ADDR) ? {rx_byte, 8'h00} : 16'h0000;

    // ----------------------------------------
    // Phase and bit counter
    // ----------------------------------------
    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        if (!cs_active) begin
            phase_d = PH_HDR; // R24
            cnt_d = '0;
        end else if (hdr_done) begin
            cnt_d = srp_pkg::HDR_BITS;
            if (in_ram) begin
                phase_d = PH_SKIP;
            end else if (in_strobe) begin
                phase_d = PH_HDR;
            end else if (in_buf) begin
                phase_d = PH_BUF;
            end else begin
                phase_d = PH_REG; // R06
            end
        end else if (reg_done || buf_done) begin
            phase_d = PH_HDR; // R10
            cnt_d = '0;
        end else if (strobe_now) begin
            cnt_d = '0; // R10 R23
        end else if (sclk_up && phase_q != PH_SKIP) begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    // ----------------------------------------
    // Output shifter
    // ----------------------------------------
    always_comb begin
        shout_d = shout_q;
        if (cs_start) begin
            shout_d = {status_byte, 8'h00}; // R13
        end else if (sclk_dn) begin
            if (cnt_q == '0 || strobe_now) begin
                shout_d = {status_byte, 8'h00}; // R13
            end else if (cnt_q == srp_pkg::HDR_BITS && phase_q != PH_SKIP) begin
                shout_d = rd_word; // R07
            end else begin
                shout_d = {shout_q[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q <= PH_HDR;
            cnt_q <= '0;
            shin_q <= '0;
            hdr_q <= '0;
            shout_q <= '0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            shout_q <= shout_d;
            if (sclk_up) begin
                shin_q <= word_in; // R08
            end
            if (hdr_done) begin
                hdr_q <= hdr_in;
            end
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Only reset clears the array; power-down has no path here
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < srp_pkg::CFG_COUNT; i++) begin
                cfg_q[i] <= '0; // R11
            end
            cfg_rd_q <= '0;
        end else begin
            if (cfg_wr) begin
                cfg_q[cfg_idx(h_addr)] <= word_in; // R09
            end
            cfg_rd_q <= cfg_hit(cfg_rd_addr) ? cfg_q[cfg_idx(cfg_rd_addr)] : 16'h0000;
        end
    end

    // ----------------------------------------
    // Status, strobes and buffer bytes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            under_q <= 1'b0;
            rssi_q <= '0;
            strobe_valid_q <= 1'b0;
            strobe_code_q <= '0;
            tx_valid_q <= 1'b0;
            tx_byte_q <= '0;
            rx_taken_q <= 1'b0;
        end else begin
            // A new underflow beats a flush in the same cycle
            if (underflow_event) begin
                under_q <= 1'b1; // R16
            end else if (flush) begin
                under_q <= 1'b0; // R16
            end
            if (!rx_enabled) begin
                rssi_q <= '0;
            end else if (!signal_strength_valid) begin
                rssi_q <= rssi_q + RW'(1); // R17
            end
            strobe_valid_q <= stb_fire; // R19
            if (stb_fire) begin
                strobe_code_q <= stb_code;
            end
            tx_valid_q <= buf_done & ~h_read & (h_addr == srp_pkg::TXBUF_ADDR);
            if (buf_done) begin
                tx_byte_q <= word_in[7:0];
            end
            rx_taken_q <= buf_done & h_read & (h_addr == srp_pkg::RXBUF_ADDR);
        end
    end

    assign link.miso = shout_q[15]; // R01
    assign strobe_valid = strobe_valid_q;
    assign strobe_code = strobe_code_q;
    assign tx_byte_valid = tx_valid_q;
    assign tx_byte = tx_byte_q;
    assign rx_byte_taken = rx_taken_q;
    assign cfg_rd_data = cfg_rd_q;
endmodule

// ---- src/srp_host.sv ----
/*
 * Master end of the serial register port, ordered through four registers of
 * its own on a plain strobe bus. One access per select period.
 * Assumes the bus master follows the single-cycle strobe protocol.
 */
module srp_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial link
    srp_if.host link,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_SHIFT = 3'b010,
        H_HOLD = 3'b011,
        H_GAP = 3'b100
    } srp_hstate_t;

    logic miso_s;

    srp_sync #(.W(1), .IDLE(1'b0)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(link.miso),
        .sync_out(miso_s),
        .rise(),
        .fall()
    );

    srp_hstate_t st_q, st_d;
    logic [srp_pkg::TMR_W-1:0] tmr_q;
    logic [srp_pkg::CNT_W-1:0] bits_q, nbits_q;
    logic [23:0] tx_q, rx_q;
    logic [15:0] wd_q, rdat_q;
    logic [7:0] status_q;
    logic sclk_q, cs_q;
    logic [31:0] rdata_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire start = wr & (addr == srp_pkg::HR_CMD) & (st_q == H_IDLE);
    wire strobe_cmd = wdata[srp_pkg::CMD_STROBE_BIT];
    wire [7:0] hdr = {1'b0, wdata[srp_pkg::CMD_READ_BIT], wdata[srp_pkg::ADDR_W-1:0]}; // R03 R04
    wire buf_cmd = hdr[srp_pkg::ADDR_W-1:0] >= srp_pkg::TXBUF_ADDR;
    wire [srp_pkg::TMR_W-1:0] limit =
        (st_q == H_SETUP) ? srp_pkg::TMR_W'(srp_pkg::CS_SETUP_CYCLES - 1) :
        (st_q == H_HOLD) ? srp_pkg::TMR_W'(srp_pkg::CS_HOLD_CYCLES - 1) :
        srp_pkg::TMR_W'(srp_pkg::SCLK_HALF_CYCLES - 1);
    wire tick = (tmr_q == limit);
    wire last_bit = (bits_q == nbits_q);
    wire busy = (st_q != H_IDLE);

    always_comb begin
        st_d = st_q;
        case (st_q)
            H_IDLE: st_d = start ? H_SETUP : H_IDLE;
            H_SETUP: st_d = tick ? H_SHIFT : H_SETUP;
            H_SHIFT: st_d = (tick && sclk_q && last_bit) ? H_HOLD : H_SHIFT;
            H_HOLD: st_d = tick ? H_GAP : H_HOLD;
            H_GAP: st_d = tick ? H_IDLE : H_GAP;
            default: st_d = H_IDLE;
        endcase
    end

    // ----------------------------------------
    // Serial engine
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= H_IDLE;
            tmr_q <= '0;
            bits_q <= '0;
            nbits_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            st_q <= st_d;
            tmr_q <= (st_q == H_IDLE || tick) ? '0 : tmr_q + srp_pkg::TMR_W'(1);
            if (start) begin
                tx_q <= {hdr, wd_q}; // R06
                nbits_q <= strobe_cmd ? srp_pkg::HDR_BITS : buf_cmd ? srp_pkg::BUF_BITS : srp_pkg::REG_BITS; // R05 R20
                bits_q <= '0;
                cs_q <= 1'b0; // R01
            end else if (st_q == H_SHIFT && tick) begin
                sclk_q <= ~sclk_q;
                if (!sclk_q) begin
                    rx_q <= {rx_q[22:0], miso_s};
                    bits_q <= bits_q + 5'h01;
                end else if (!last_bit) begin
                    tx_q <= {tx_q[22:0], 1'b0};
                end
            end else if (st_q == H_HOLD && tick) begin
                cs_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    wire done = (st_q == H_HOLD) && tick;
    wire [31:0] rd_mux =
        (addr == srp_pkg::HR_WDATA) ? {16'h0000, wd_q} :
        (addr == srp_pkg::HR_STATUS) ? {23'h000000, busy, status_q} :
        (addr == srp_pkg::HR_RDATA) ? {16'h0000, rdat_q} : 32'h00000000;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wd_q <= '0;
            rdat_q <= '0;
            status_q <= '0;
            rdata_q <= '0;
        end else begin
            if (wr && addr == srp_pkg::HR_WDATA) begin
                wd_q <= wdata[15:0];
            end
            if (done) begin
                status_q <= rx_q[nbits_q - 5'h01 -: 8];
                rdat_q <= rx_q[15:0];
            end
            rdata_q <= rd ? rd_mux : 32'h00000000;
        end
    end

    assign link.sclk = sclk_q;
    assign link.chip_select_low = cs_q;
    assign link.mosi = tx_q[23];
    assign rdata = rdata_q;
endmodule

// ---- tb/srp_checker.sv ----
/* Checker for the four serial wires between the two ends.
   Assumes mode 0 framing by the host end and one system clock. */
module srp_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic chip_select_low,
    input wire logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Rising edges within one select period
    // ----------------------------------------
    logic sclk_q;
    logic [4:0] bits_q;
    logic [4:0] bits_d;
    assign bits_d = chip_select_low ? 5'h00 : bits_q + {4'h0, sclk & ~sclk_q};
    always_ff @(posedge clock) begin
        sclk_q <= rst_n ? sclk : 1'b0;
        bits_q <= rst_n ? bits_d : 5'h00;
    end
    a_idle_clock_low: assert property (chip_select_low |-> !sclk)
        else $error("serial clock high while deselected");
    a_select_setup: assert property ($fell(chip_select_low) |-> !sclk [*3])
        else $error("serial clock rose too soon after select");
    a_select_hold: assert property ($rose(chip_select_low) |-> !$past(sclk, 3))
        else $error("select released too soon after last falling edge");
    a_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase not eight cycles");
    a_frame_bits: assert property ($rose(chip_select_low) |->
        bits_q == 5'h08 || bits_q == 5'h10 || bits_q == 5'h18)
        else $error("frame length not 8, 16 or 24 bits");
    a_mosi_steady: assert property (!chip_select_low && sclk && sclk_q |-> $stable(mosi))
        else $error("data in changed while serial clock high");
    a_miso_steady: assert property (!chip_select_low && sclk && sclk_q |-> $stable(miso))
        else $error("data out changed while serial clock high");
    a_status_msb: assert property (!chip_select_low && sclk && !sclk_q && bits_q == 5'h00 |-> !miso)
        else $error("first status bit not zero");
    a_frame_gap: assert property ($rose(chip_select_low) |-> chip_select_low [*6])
        else $error("select gap too short");
endmodule

// ---- tb/serial_register_port_tb_top.sv ----
/* Bench joining host and device ends over one link, with queue-based checks.
   Assumes the package's host register map and a shortened signal-valid wait. */
module serial_register_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, wr, rd, mark, mark_q, unf_m;
    logic oscillator_running, underflow_event, cipher_busy, tx_active, pll_lock, rx_enabled;
    logic strobe_valid, tx_byte_valid, rx_byte_taken;
    logic [3:0] addr, strobe_code;
    logic [7:0] tx_byte, rx_byte;
    logic [5:0] cfg_rd_addr, a;
    logic [15:0] cfg_rd_data;
    logic [31:0] wdata, rdata, seed, got, d;
    logic [31:0] exp_q[$], buf_q[$];
    logic [31:0] msk_q[$];
    logic [3:0] stb_q[$];
    int errors, n_tests;
    srp_if srp_if_inst ();
    srp_device #(.RSSI_WAIT(20)) srp_device_inst (.clock(clock), .rst_n(rst_n), .link(srp_if_inst),
        .oscillator_running(oscillator_running), .underflow_event(underflow_event), .cipher_busy(cipher_busy),
        .tx_active(tx_active), .pll_lock(pll_lock), .rx_enabled(rx_enabled), .strobe_valid(strobe_valid),
        .strobe_code(strobe_code), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .rx_byte(rx_byte),
        .rx_byte_taken(rx_byte_taken), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data));
    srp_host srp_host_inst (.clock(clock), .rst_n(rst_n), .link(srp_if_inst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    srp_checker srp_checker_inst (.clock(clock), .rst_n(rst_n), .sclk(srp_if_inst.sclk),
        .chip_select_low(srp_if_inst.chip_select_low), .mosi(srp_if_inst.mosi), .miso(srp_if_inst.miso));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        n_tests++;
        if ((g & m) !== (e & m)) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g & m, e & m);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Register port master
    // ----------------------------------------
    task automatic bus_wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge clock);
        addr <= ad;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] ad, input logic c, output logic [31:0] v);
        @(posedge clock);
        addr <= ad;
        rd <= 1'b1;
        mark <= c;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
        v = rdata;
    endtask
    task automatic expect_rd(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus_rd(ad, 1'b1, got);
    endtask
    // Polls busy; a frame that never ends closes the run
    task automatic frame(input logic [31:0] cmd);
        int i;
        bus_wr(srp_pkg::HR_CMD, cmd);
        for (i = 0; i < 2000; i++) begin
            bus_rd(srp_pkg::HR_STATUS, 1'b0, got);
            if (got[srp_pkg::STS_BUSY_BIT] === 1'b0) break;
        end
        if (i == 2000) begin
            errors++;
            $display("[FAIL] %0t frame never ended", $time);
            results();
        end
    endtask
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge clock) begin
        mark_q <= rd & mark;
        if (mark_q === 1'b1) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0, 32'h1);
            else chk(rdata, exp_q.pop_front(), msk_q.pop_front());
        end
        if (strobe_valid === 1'b1) begin
            if (stb_q.size() == 0) chk(32'h1, 32'h0, 32'h1);
            else chk({28'h0, strobe_code}, {28'h0, stb_q.pop_front()}, 32'h0000000F);
        end
        if ((tx_byte_valid | rx_byte_taken) === 1'b1)
            chk({22'h0, tx_byte_valid, rx_byte_taken, tx_byte},
                buf_q.size() ? buf_q.pop_front() : 32'h0, 32'h3FF);
    end
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        $display("[FAIL] %0t run limit reached", $time);
        results();
    end
    initial begin
        {rst_n, wr, rd, mark, unf_m, underflow_event} = 6'h00;
        {oscillator_running, cipher_busy, tx_active, pll_lock, rx_enabled} = 5'h00;
        addr = 4'h0;
        wdata = 32'h0;
        rx_byte = 8'h00;
        cfg_rd_addr = 6'h10;
        seed = 32'h72D976E2;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        // Every strobe code, oscillator off then on; status tracked per frame
        for (int o = 0; o < 2; o++) begin
            for (int c = 0; c < 15; c++) begin
                seed = xs(seed);
                @(posedge clock);
                oscillator_running <= o[0];
                {cipher_busy, tx_active, pll_lock, rx_enabled} <= seed[3:0];
                rx_byte <= seed[15:8];
                underflow_event <= (c == 3);
                @(posedge clock);
                underflow_event <= 1'b0;
                unf_m = unf_m | (c == 3);
                repeat (25) @(posedge clock);
                if (c == 1 || (o == 1 && c != 0)) stb_q.push_back(c[3:0]);
                frame({23'h0, 3'b100, c[5:0]});
                expect_rd(srp_pkg::HR_STATUS, {24'h0, 1'b0, o[0], unf_m, seed[3:0], 1'b0}, 32'h17E);
                if (o == 1 && c == 9) unf_m = 1'b0;
            end
            $display("strobe scan %0d done", o);
        end
        // Registers in random order, both ends of the map, one unmapped
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a = (i == 0) ? 6'h10 : (i == 1) ? 6'h30 : (i == 5) ? 6'h31 : 6'h10 + {1'b0, seed[20:16]};
            d = (a == 6'h31) ? 32'h0 : {16'h0, seed[15:0]};
            bus_wr(srp_pkg::HR_WDATA, {16'h0, seed[15:0]});
            frame({24'h0, 2'b00, a});
            @(posedge clock);
            cfg_rd_addr <= a;
            @(posedge clock);
            @(posedge clock);
            chk({16'h0, cfg_rd_data}, d, 32'h0000FFFF);
            bus_wr(srp_pkg::HR_WDATA, {16'h0, ~seed[15:0]});
            frame({24'h0, 2'b01, a});
            expect_rd(srp_pkg::HR_RDATA, d, 32'h0000FFFF);
        end
        bus_wr(srp_pkg::HR_WDATA, {16'h0, seed[31:24], 8'h00});
        buf_q = '{{22'h0, 2'b10, seed[31:24]}, {22'h0, 2'b01, seed[31:24]}};
        frame({24'h0, 2'b00, srp_pkg::TXBUF_ADDR});
        expect_rd(srp_pkg::HR_RDATA, {24'h0, 3'b010, 5'h00}, 32'h60);
        frame({24'h0, 2'b01, srp_pkg::RXBUF_ADDR});
        expect_rd(srp_pkg::HR_RDATA, {24'h0, rx_byte}, 32'hFF);
        expect_rd(4'h2, 32'h0, 32'hFFFFFFFF);
        $display("register scan done");
        repeat (4) @(posedge clock);
        chk(32'(exp_q.size() + stb_q.size() + buf_q.size()), 32'h0, 32'hFFFFFFFF);
        results();
    end
endmodule
